// [hdl/cpsl_consts.svh]
// Constants for the consumption pulse and status indicator block
`ifndef CPSL_CONSTS_SVH
`define CPSL_CONSTS_SVH
`define CPSL_CLK_HZ 50000000
`define CPSL_SECOND_CYC (`CPSL_CLK_HZ)
`define CPSL_W_LONG_MS 120
`define CPSL_W_MID_MS 60
`define CPSL_W_SHORT_MS 30
`define CPSL_CYC_PER_MS (`CPSL_CLK_HZ / 1000)
`define CPSL_FLOW_MID 3
`define CPSL_FLOW_HIGH 6
`define CPSL_BLINK_CYC 12500000
`endif

// [hdl/cpsl_pkg.sv]
// Types shared by the consumption pulse block
package cpsl_pkg;
    typedef enum logic [1:0] {
        CPSL_IDLE,
        CPSL_HIGH,
        CPSL_GAP
    } cpsl_state_t;
endpackage

// [hdl/cpsl_timer.sv]
// Down-counting interval timer used for pulse high and gap phases
`timescale 1ns/10ps
`default_nettype none
module cpsl_timer #(
    parameter int CW = 32
) (
    input wire logic mclk,
    input wire logic arst_n,
    cpsl_tmr_if.tmr t
);
    logic [CW-1:0] cnt_q;
    logic run_q;

    // Done pulses for one cycle when the loaded count runs out
    assign t.done = run_q && (cnt_q == '0);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
            run_q <= 1'b0;
        end else if (t.load) begin
            cnt_q <= t.count - 1'b1;
            run_q <= 1'b1;
        end else if (run_q) begin
            cnt_q <= cnt_q - 1'b1;
            run_q <= (cnt_q != '0);
        end
    end
endmodule // cpsl_timer
`default_nettype wire

// [hdl/cpsl_tmr_if.sv]
// Interface between the pulse sequencer and its interval timer
`timescale 1ns/10ps
`default_nettype none
interface cpsl_tmr_if #(parameter int CW = 32);
    logic load;
    logic [CW-1:0] count;
    logic done;
    modport ctl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface // cpsl_tmr_if
`default_nettype wire

// [hdl/cpsl_top.sv]
// Consumption pulse generator and front-panel status indicators
//
// Behaviour
// - One switch pulse per whole consumption unit accumulated.
// - Volume summed per one-second interval; pulses released after the second.
// - Pulse width 120 ms up to flow 3, 60 ms above 3, 30 ms above 6.
// - Logger indicator steady on while flash is formatting.
// - Logger indicator blinks while recording, dark otherwise.
// - Flow indicator steady while display shows flow; never blinks.
// - Pressure indicator steady while display shows pressure; never blinks.
// - Link indicator steady while wireless link is up; never blinks.
`include "cpsl_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module cpsl_top
    import cpsl_pkg::*;
#(
    parameter int VW = 24,
    parameter int FW = 16,
    parameter int QW = 24,
    parameter int SECOND_CYC = `CPSL_SECOND_CYC,
    parameter int W_LONG_CYC = `CPSL_W_LONG_MS * `CPSL_CYC_PER_MS,
    parameter int W_MID_CYC = `CPSL_W_MID_MS * `CPSL_CYC_PER_MS,
    parameter int W_SHORT_CYC = `CPSL_W_SHORT_MS * `CPSL_CYC_PER_MS,
    parameter int BLINK_CYC = `CPSL_BLINK_CYC
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic vol_valid,
    input wire logic [VW-1:0] vol_units,
    input wire logic [FW-1:0] flow_rate,
    input wire logic log_formatting,
    input wire logic log_recording,
    input wire logic disp_is_flow,
    input wire logic disp_is_pressure,
    input wire logic link_connected,
    output logic pulse_switch_out,
    output logic [QW-1:0] pulses_owed,
    output logic led_logger,
    output logic led_flow,
    output logic led_pressure,
    output logic led_link
);
    localparam int CW = 32;

    cpsl_state_t state_q;
    cpsl_tmr_if #(.CW(CW)) tif ();

    logic [CW-1:0] sec_q;
    logic [QW-1:0] acc_q;
    logic [QW-1:0] owe_q;
    logic [CW-1:0] width_q;
    logic [CW-1:0] blink_q;
    logic blink_ph_q;
    logic sw_q;

    // Second boundary and width selection from the present flow
    wire sec_end = (sec_q == CW'(SECOND_CYC - 1));
    wire flow_high = flow_rate > FW'(`CPSL_FLOW_HIGH);
    wire flow_mid = flow_rate > FW'(`CPSL_FLOW_MID);
    wire [CW-1:0] width_sel = flow_high ? CW'(W_SHORT_CYC) :
        flow_mid ? CW'(W_MID_CYC) : CW'(W_LONG_CYC);
    wire start = (state_q == CPSL_IDLE) && (owe_q != '0);
    wire [QW-1:0] owe_dec = (start ? QW'(1) : QW'(0));
    wire [QW-1:0] acc_add = vol_valid ? QW'(vol_units) : QW'(0);

    // One-second interval counter
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sec_q <= '0;
        end else begin
            sec_q <= sec_end ? '0 : sec_q + 1'b1;
        end
    end

    // Units gathered before the last cycle of a second move to the owed queue at its end; last-cycle units start the next second
    // Saturation is not applied; the queue is sized far beyond one second of flow
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            acc_q <= '0;
            owe_q <= '0;
        end else if (sec_end) begin
            acc_q <= acc_add;
            owe_q <= owe_q + acc_q + acc_add - owe_dec - acc_add;
        end else begin
            acc_q <= acc_q + acc_add;
            owe_q <= owe_q - owe_dec;
        end
    end

    // Timer is loaded with the pulse width at start and again for the gap
    assign tif.load = start || ((state_q == CPSL_HIGH) && tif.done);
    assign tif.count = start ? width_sel : width_q;

    cpsl_timer #(.CW(CW)) u_timer (
        .mclk(mclk),
        .arst_n(arst_n),
        .t(tif)
    );

    // Pulse sequencer: high phase then a gap of equal length
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= CPSL_IDLE;
            width_q <= '0;
            sw_q <= 1'b0;
        end else begin
            case (state_q)
                CPSL_IDLE: begin
                    if (start) begin
                        state_q <= CPSL_HIGH;
                        width_q <= width_sel;
                        sw_q <= 1'b1;
                    end
                end
                CPSL_HIGH: begin
                    if (tif.done) begin
                        state_q <= CPSL_GAP;
                        sw_q <= 1'b0;
                    end
                end
                CPSL_GAP: begin
                    if (tif.done) begin
                        state_q <= CPSL_IDLE;
                    end
                end
                default: begin
                    state_q <= CPSL_IDLE;
                    sw_q <= 1'b0;
                end
            endcase
        end
    end

    // Free-running blink phase for the logger indicator
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            blink_q <= '0;
            blink_ph_q <= 1'b0;
        end else if (blink_q == CW'(BLINK_CYC - 1)) begin
            blink_q <= '0;
            blink_ph_q <= ~blink_ph_q;
        end else begin
            blink_q <= blink_q + 1'b1;
        end
    end

    // Indicators are registered so they never glitch; formatting outranks recording
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            led_logger <= 1'b0;
            led_flow <= 1'b0;
            led_pressure <= 1'b0;
            led_link <= 1'b0;
        end else begin
            led_logger <= log_formatting | (log_recording & blink_ph_q);
            led_flow <= disp_is_flow;
            led_pressure <= disp_is_pressure;
            led_link <= link_connected;
        end
    end

    assign pulse_switch_out = sw_q;
    assign pulses_owed = owe_q;
endmodule // cpsl_top
`default_nettype wire

// [tb/cpsl_checker_assertions.sv]
// Port-level checks for the pulse and indicator block
`timescale 1ns/10ps
`default_nettype none
module cpsl_checker (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic log_formatting,
    input wire logic log_recording,
    input wire logic disp_is_flow,
    input wire logic disp_is_pressure,
    input wire logic link_connected,
    input wire logic pulse_switch_out,
    input wire logic [23:0] pulses_owed,
    input wire logic led_logger,
    input wire logic led_flow,
    input wire logic led_pressure,
    input wire logic led_link
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    flow_led_a: assert property (led_flow == $past(disp_is_flow)) else $error("flow led");
    press_led_a: assert property (led_pressure == $past(disp_is_pressure)) else $error("press led");
    link_led_a: assert property (led_link == $past(link_connected)) else $error("link led");
    format_on_a: assert property ($past(log_formatting) |-> led_logger) else $error("format");
    logger_dark_a: assert property (!$past(log_formatting) && !$past(log_recording) |-> !led_logger)
        else $error("logger lit");
    owed_take_a: assert property ($rose(pulse_switch_out) |-> pulses_owed == $past(pulses_owed) - 24'h1)
        else $error("owed");
    pulse_min_a: assert property ($rose(pulse_switch_out) |=> pulse_switch_out[*2]) else $error("short");
    gap_min_a: assert property ($fell(pulse_switch_out) |=> !pulse_switch_out[*2]) else $error("gap");
    idle_open_a: assert property (!pulse_switch_out && pulses_owed == 24'h0 |=> !pulse_switch_out)
        else $error("stray");
endmodule // cpsl_checker
bind cpsl_top cpsl_checker cpsl_checker_i (.*);
`default_nettype wire

// [tb/cpsl_counter.sv]
// External pulse counter model that totals switch closures
`timescale 1ns/10ps
`default_nettype none
module cpsl_counter (
    input wire logic mclk,
    input wire logic sw,
    output logic [15:0] total,
    output logic [15:0] width
);
    logic [15:0] run_q = 16'h0;
    initial total = 16'h0;
    initial width = 16'h0;
    // Counts on release, so a merged pulse shows up as one long width
    always @(posedge mclk) begin
        if (sw) begin
            run_q <= run_q + 16'h1;
        end else if (run_q != 16'h0) begin
            total <= total + 16'h1;
            width <= run_q;
            run_q <= 16'h0;
        end
    end
endmodule // cpsl_counter
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the pulse and indicator block
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic vol_valid = 1'b0;
    logic [23:0] vol_units = 24'h0;
    logic [15:0] flow_rate = 16'h0;
    logic [4:0] st = 5'h0; // Format, record, flow, pressure, link
    logic sw, led_lg, led_fl, led_pr, led_lk;
    logic [23:0] owed;
    logic [15:0] total, width, base;
    logic [15:0] flows [3] = '{16'h3, 16'h6, 16'h7};
    int widths [3] = '{12, 6, 3};
    int miscompares = 0, comparisons = 0, cyc = 0, k, n;
    always #10 mclk = ~mclk;
    always @(posedge mclk) if (arst_n) cyc <= cyc + 1;
    cpsl_top #(.SECOND_CYC(100), .W_LONG_CYC(12), .W_MID_CYC(6), .W_SHORT_CYC(3), .BLINK_CYC(4))
    cpsl_top_i (.mclk(mclk), .arst_n(arst_n), .vol_valid(vol_valid), .vol_units(vol_units),
        .flow_rate(flow_rate), .log_formatting(st[0]), .log_recording(st[1]),
        .disp_is_flow(st[2]), .disp_is_pressure(st[3]), .link_connected(st[4]),
        .pulse_switch_out(sw), .pulses_owed(owed), .led_logger(led_lg), .led_flow(led_fl),
        .led_pressure(led_pr), .led_link(led_lk));
    cpsl_counter cpsl_counter_i (.mclk(mclk), .sw(sw), .total(total), .width(width));
    task step(input int c);
        repeat (c) @(negedge mclk);
    endtask
    task chk(input bit ok, input string m);
        comparisons++;
        if (!ok) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task results;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        step(3);
        chk(sw === 1'b0 && owed === 24'h0, "switch closed in reset");
        arst_n = 1'b1;
        // One indicator input at a time; recording only blinks, checked below
        for (k = 0; k < 5; k++) begin
            st = 5'h1 << k;
            step(2);
            if (k != 1) chk({led_lg, led_fl, led_pr, led_lk} === {st[0], st[2], st[3], st[4]}, "leds");
        end
        st = 5'h2;
        n = 0;
        repeat (16) begin
            step(1);
            n += (led_lg === 1'b1);
        end
        chk(n >= 4 && n <= 12, "logger not blinking");
        st = 5'h0;
        $display("test leds done");
        // Two units back to back mid-second, one run per width band
        for (k = 0; k < 3; k++) begin
            while (cyc % 100 != 50) step(1);
            base = total;
            flow_rate = flows[k];
            vol_valid = 1'b1;
            vol_units = 24'h1;
            step(2);
            vol_valid = 1'b0;
            chk(owed === 24'h0 && sw === 1'b0, "early pulse");
            n = 0;
            while (total !== base + 16'h2 && n < 400) begin
                step(1);
                n++;
            end
            chk(total === base + 16'h2 && width === 16'(widths[k]), "pulse count or width");
        end
        $display("test pulses done");
        results;
    end
    // A hang costs one miscompare and ends the run through the same path
    initial begin
        #100000;
        miscompares++;
        results;
    end
endmodule // tb
`default_nettype wire
